//--- core/gmc_pkg.sv
// package for the gauge mode and command register bank
// assumes byte-wide register access at the printed addresses
package gmc_pkg;
  localparam logic [6:0] ADDR_CONTROL = 7'h00;
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_RATE_LO = 7'h02;
  localparam logic [6:0] ADDR_RATE_HI = 7'h03;
  localparam logic [6:0] ADDR_RUN_LO = 7'h04;
  localparam logic [6:0] ADDR_RUN_HI = 7'h05;
  localparam logic [6:0] ADDR_HEAT_LO = 7'h06;
  localparam logic [6:0] ADDR_HEAT_HI = 7'h07;
  localparam logic [6:0] ADDR_OFS_LO = 7'h5e;
  localparam logic [6:0] ADDR_OFS_HI = 7'h5f;
  localparam logic [7:0] KEY_GAUGE = 8'ha9;
  localparam logic [7:0] KEY_OFFSET = 8'h56;
  localparam int BIT_DIR = 7;
  localparam int BIT_LEVEL = 6;
  localparam int BIT_LOAD = 5;
  localparam int BIT_DONE = 4;
  localparam int BIT_PART_RST = 3;
  localparam int BIT_POWERON = 2;
  localparam int BIT_FULL_RST = 1;
  localparam int BIT_SHIP = 0;
  localparam int BIT_CFG_DIR = 7;
  localparam logic [7:0] CMD_MASK = 8'h3b;
  localparam logic [7:0] KEEP_MASK = 8'hc4;
  localparam logic [7:0] MODE_RESET = 8'h44;
  localparam int CLK_HZ = 100000000;
  localparam int OFFSET_TIME_MS = 5500;
  localparam int HEAT_TIME_MS = 2560;
  localparam int OFFSET_CYCLES = OFFSET_TIME_MS / 1000 * CLK_HZ
                                 + (OFFSET_TIME_MS % 1000) * (CLK_HZ / 1000);
  localparam int HEAT_CYCLES = HEAT_TIME_MS * (CLK_HZ / 1000);
  localparam int MINUTES_FACTOR = 60;
  typedef enum logic [2:0] {GMC_NONE, GMC_LOAD, GMC_DONE, GMC_PART_RST,
                            GMC_FULL_RST, GMC_SHIP, GMC_EXT_OFS,
                            GMC_INT_OFS} gmc_cmd_t;
endpackage : gmc_pkg

//--- core/gmc_cmd_if.sv
// carrier between the register bank and its runtime divider
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none
interface gmc_cmd_if;
  logic start; // one-cycle request
  logic [31:0] dividend; // rate capacity times 60
  logic [15:0] divisor; // rate current
  logic busy; // division under way
  logic done; // one-cycle result strobe
  logic [15:0] quotient; // minutes
  modport bank (output start, dividend, divisor, input busy, done, quotient);
  modport divider (input start, dividend, divisor, output busy, done,
                   quotient);
endinterface : gmc_cmd_if
`default_nettype wire

//--- core/gmc_runtime_div.sv
// serial restoring divider for the at-rate runtime
// assumes requests only while not busy
`timescale 1ns/1ns
`default_nettype none
module gmc_runtime_div
  import gmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  gmc_cmd_if.divider port
);
  logic [31:0] rem; // partial remainder
  logic [31:0] quo; // quotient shift register
  logic [15:0] den; // held divisor
  logic [5:0] steps; // bits left
  logic [32:0] trial; // shifted remainder
  assign trial = {rem, quo[31]};

  // one quotient bit per clock; zero divisor saturates
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem <= '0;
      quo <= '0;
      den <= '0;
      steps <= '0;
      port.busy <= 1'b0;
      port.done <= 1'b0;
      port.quotient <= '0;
    end
    else
    begin
      port.done <= 1'b0;
      if (port.start && !port.busy)
      begin
        rem <= '0;
        quo <= port.dividend;
        den <= port.divisor;
        steps <= 6'd32;
        port.busy <= 1'b1;
      end
      else if (port.busy)
      begin
        if (steps == 6'd0)
        begin
          port.busy <= 1'b0;
          port.done <= 1'b1;
          // saturate on zero rate or overflow
          if (den == 16'h0000 || quo[31:16] != 16'h0000)
            port.quotient <= 16'hffff;
          else
            port.quotient <= quo[15:0];
        end
        else
        begin
          steps <= steps - 6'd1;
          if (trial >= {17'h00000, den})
          begin
            rem <= 32'(trial - {17'h00000, den});
            quo <= {quo[30:0], 1'b1};
          end
          else
          begin
            rem <= trial[31:0];
            quo <= {quo[30:0], 1'b0};
          end
        end
      end
    end
  end
endmodule : gmc_runtime_div
`default_nettype wire

//--- core/gmc_mode_regs.sv
// mode, control, at-rate, runtime, heat and offset registers
// assumes a byte register port from the serial link decoder
`timescale 1ns/1ns
`default_nettype none
module gmc_mode_regs
  import gmc_pkg::*;
#(
  parameter int OFFSET_WAIT = OFFSET_CYCLES,
  parameter int HEAT_WAIT = HEAT_CYCLES,
  parameter logic [15:0] LAST_DISCHARGE_INIT = 16'h0000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [7:0] pack_config_byte,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  input wire logic [15:0] heatSample,
  input wire logic [15:0] offsetSample,
  input wire logic [15:0] rate_capacity,
  input wire logic fullCharge,
  input wire logic exitProgram,
  output logic [15:0] nominal_capacity,
  output logic [15:0] last_discharge_capacity,
  output logic learning_invalid_flag,
  output logic partialResetPulse,
  output logic fullResetPulse,
  output logic shipMode,
  output logic calibrating,
  output logic internalShort
);
  logic [7:0] modeBits; // stored mode byte
  logic [7:0] control; // control byte
  logic [15:0] rate_current; // at-rate current
  logic [15:0] rate_runtime; // predicted minutes
  logic [15:0] heat; // die heat reading
  logic [15:0] offsetResult; // offset measurement result
  logic cfgPending; // direction load still due
  logic [31:0] calCount; // offset measurement timer
  logic [31:0] heatCount; // heat refresh timer
  logic keyGauge; // gauge key written
  logic keyOffset; // offset key written
  gmc_cmd_t pick; // selected command
  logic [7:0] levelRead; // mode byte as read
  logic shipExit; // leaving ship mode
  logic [15:0] heatSnap; // periodic snapshot
  gmc_cmd_if div ();

  assign keyGauge = regWrite && regAddr == ADDR_CONTROL
                    && regWdata == KEY_GAUGE;
  assign keyOffset = regWrite && regAddr == ADDR_CONTROL
                     && regWdata == KEY_OFFSET;
  assign shipExit = shipMode && regWrite; // any host write wakes it

  // priority pick among command bits, highest bit first
  always_comb
  begin
    pick = GMC_NONE;
    if (keyGauge)
    begin
      if (modeBits[BIT_LOAD])
        pick = GMC_LOAD;
      else if (modeBits[BIT_DONE])
        pick = GMC_DONE;
      else if (modeBits[BIT_PART_RST])
        pick = GMC_PART_RST;
      else if (modeBits[BIT_FULL_RST])
        pick = GMC_FULL_RST;
      else if (modeBits[BIT_SHIP])
        pick = GMC_SHIP;
    end
    else if (keyOffset && calCount == 32'd0)
    begin
      if (modeBits[BIT_LOAD])
        pick = GMC_EXT_OFS;
      else if (modeBits[BIT_DONE])
        pick = GMC_INT_OFS;
    end
  end

  // mode byte: keep bits from host, command bits cleared after run
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeBits <= MODE_RESET; // level and power-on set
      cfgPending <= 1'b1;
    end
    else
    begin
      if (cfgPending)
      begin
        modeBits[BIT_DIR] <= pack_config_byte[BIT_CFG_DIR];
        cfgPending <= 1'b0;
      end
      else if (regWrite && regAddr == ADDR_MODE)
        modeBits <= regWdata;
      else if (pick != GMC_NONE)
        modeBits <= modeBits & KEEP_MASK;
      // hardware clear of power-on flag yields to the direction load and to a host mode write
      if (!cfgPending && (fullCharge || exitProgram || shipExit)
          && !(regWrite && regAddr == ADDR_MODE))
        modeBits[BIT_POWERON] <= 1'b0;
    end
  end

  // control byte stores writes; either key value clears it, accepted or not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      control <= 8'h00;
    else if (keyGauge || keyOffset)
      control <= 8'h00;
    else if (regWrite && regAddr == ADDR_CONTROL)
      control <= regWdata; // stored only, no action
  end

  // at-rate current, host-written; feeds the divider and the load command, reset commands clear it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rate_current <= 16'h0000;
    else if (pick == GMC_PART_RST || pick == GMC_FULL_RST)
      rate_current <= 16'h0000;
    else if (regWrite && regAddr == ADDR_RATE_LO)
      rate_current[7:0] <= regWdata;
    else if (regWrite && regAddr == ADDR_RATE_HI)
      rate_current[15:8] <= regWdata;
  end

  // capacity registers touched by the gauge commands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nominal_capacity <= 16'h0000;
      last_discharge_capacity <= LAST_DISCHARGE_INIT;
      learning_invalid_flag <= 1'b1;
    end
    else
    begin
      unique case (pick)
        GMC_LOAD: nominal_capacity <= rate_current;
        GMC_DONE: nominal_capacity <= last_discharge_capacity;
        GMC_FULL_RST:
        begin
          nominal_capacity <= 16'h0000;
          last_discharge_capacity <= LAST_DISCHARGE_INIT;
          learning_invalid_flag <= 1'b1;
        end
        default: ; // partial reset spares these
      endcase
    end
  end

  // reset pulses and ship mode toward the rest of the gauge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      partialResetPulse <= 1'b0;
      fullResetPulse <= 1'b0;
      shipMode <= 1'b0;
    end
    else
    begin
      partialResetPulse <= pick == GMC_PART_RST;
      fullResetPulse <= pick == GMC_FULL_RST;
      if (pick == GMC_SHIP)
        shipMode <= 1'b1;
      else if (shipExit)
        shipMode <= 1'b0;
    end
  end

  // offset measurement timer and result capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calCount <= 32'd0;
      calibrating <= 1'b0;
      internalShort <= 1'b0;
      offsetResult <= 16'h0000;
    end
    else if (pick == GMC_EXT_OFS || pick == GMC_INT_OFS)
    begin
      calCount <= 32'(OFFSET_WAIT);
      calibrating <= 1'b1;
      internalShort <= pick == GMC_INT_OFS;
    end
    else if (calCount != 32'd0)
    begin
      calCount <= calCount - 32'd1;
      if (calCount == 32'd1)
      begin
        calibrating <= 1'b0;
        internalShort <= 1'b0;
        offsetResult <= offsetSample;
      end
    end
  end

  // heat refresh; a limitation: reading straddling refresh may tear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      heatCount <= 32'd0;
      heat <= 16'h0000;
    end
    else if (heatCount == 32'd0)
    begin
      heatCount <= 32'(HEAT_WAIT - 1);
      heat <= heatSample;
    end
    else
      heatCount <= heatCount - 32'd1;
  end
  assign heatSnap = heat;

  // runtime: restart the divider whenever idle
  assign div.start = !div.busy && !div.done;
  assign div.dividend = 32'(rate_capacity) * 32'(MINUTES_FACTOR);
  assign div.divisor = rate_current;
  gmc_runtime_div divider (
    .clk(clk),
    .rst_n(rst_n),
    .port(div)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rate_runtime <= 16'h0000;
    else if (div.done)
      rate_runtime <= div.quotient;
  end

  // pin: input when direction bit set, else open drain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end
    else
    begin
      pinOut <= 1'b0;
      pinOe <= !modeBits[BIT_DIR] && !modeBits[BIT_LEVEL];
    end
  end

  // level bit reads the pin in input mode
  always_comb
  begin
    levelRead = modeBits;
    if (modeBits[BIT_DIR])
      levelRead[BIT_LEVEL] = pinIn;
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      unique case (regAddr)
        ADDR_CONTROL: regRdata <= control;
        ADDR_MODE: regRdata <= levelRead;
        ADDR_RATE_LO: regRdata <= rate_current[7:0];
        ADDR_RATE_HI: regRdata <= rate_current[15:8];
        ADDR_RUN_LO: regRdata <= rate_runtime[7:0];
        ADDR_RUN_HI: regRdata <= rate_runtime[15:8];
        ADDR_HEAT_LO: regRdata <= heatSnap[7:0];
        ADDR_HEAT_HI: regRdata <= heatSnap[15:8];
        ADDR_OFS_LO: regRdata <= offsetResult[7:0];
        ADDR_OFS_HI: regRdata <= offsetResult[15:8];
        default: regRdata <= 8'h00;
      endcase
    end
  end
endmodule : gmc_mode_regs
`default_nettype wire

//--- tb/gmc_mode_regs_props.sv
// checker for the mode and command register bank
// assumes it is bound to gmc_mode_regs and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module gmc_mode_regs_props
  import gmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic [15:0] nominal_capacity,
  input wire logic [15:0] last_discharge_capacity,
  input wire logic partialResetPulse,
  input wire logic fullResetPulse,
  input wire logic shipMode,
  input wire logic calibrating,
  input wire logic internalShort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] modeW; // shadow of the last mode byte written
  logic ctlW; // any write to the control register
  logic keyG; // gauge key written
  logic keyO; // offset key written
  assign ctlW = regWrite && regAddr == ADDR_CONTROL;
  assign keyG = ctlW && regWdata == KEY_GAUGE;
  assign keyO = ctlW && regWdata == KEY_OFFSET;
  // shadow drops its command bits after an accepted key, as the bank does;
  // an offset key refused during a measurement leaves them in place
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeW <= 8'h00;
    end
    else if (regWrite && regAddr == ADDR_MODE)
    begin
      modeW <= regWdata;
    end
    else if (keyG || (keyO && |modeW[5:4] && !calibrating))
    begin
      modeW <= modeW & ~CMD_MASK;
    end
  end
  a_done_cap: assert property (keyG && modeW[5:4] == 2'b01 |=>
    nominal_capacity == $past(last_discharge_capacity))
    else $error("done command did not load capacity");
  a_part_reset: assert property (keyG && modeW[5:3] == 3'b001 |=>
    partialResetPulse && !fullResetPulse)
    else $error("partial reset not run");
  a_full_reset: assert property (keyG && modeW[5:3] == 3'b000
    && modeW[1] |=> fullResetPulse && !partialResetPulse)
    else $error("full reset not run");
  a_ship_enter: assert property (keyG && modeW[5:3] == 3'b000
    && modeW[1:0] == 2'b01 |=> shipMode)
    else $error("ship mode not entered");
  a_cal_start: assert property (keyO && |modeW[5:4] && !calibrating
    |=> calibrating)
    else $error("offset measurement not started");
  a_int_short: assert property (keyO && modeW[5:4] == 2'b01
    && !calibrating |=> internalShort)
    else $error("inputs not shorted");
  a_ext_open: assert property (keyO && modeW[5] && !calibrating
    |=> !internalShort)
    else $error("inputs shorted on external offset");
  a_bad_key: assert property (ctlW && !keyG && !keyO |=>
    !partialResetPulse && !fullResetPulse && $stable(nominal_capacity))
    else $error("command run without key");
  a_pin_low: assert property (pinOut == 1'b0)
    else $error("pin output not low");
  // driver enable settles one cycle after the mode byte has been stored
  a_oe_follow: assert property (regWrite && regAddr == ADDR_MODE
    |=> ##1 pinOe == !($past(regWdata[7], 2) || $past(regWdata[6], 2)))
    else $error("pin driver does not follow mode byte");
endmodule : gmc_mode_regs_props
bind gmc_mode_regs gmc_mode_regs_props u_props (.clk(clk), .rst_n(rst_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .pinOut(pinOut), .pinOe(pinOe), .nominal_capacity(nominal_capacity),
  .last_discharge_capacity(last_discharge_capacity),
  .partialResetPulse(partialResetPulse), .fullResetPulse(fullResetPulse),
  .shipMode(shipMode), .calibrating(calibrating),
  .internalShort(internalShort));
`default_nettype wire

//--- tb/gmc_host_model.sv
// host side: register requests and the pulled-up gpio line
// assumes one clock shared with the register bank
`timescale 1ns/1ns
`default_nettype none
module gmc_host_model
(
  input wire logic clk,
  input wire logic pinOe,
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata,
  output logic pinIn
);
  logic pinLow; // host pulls the line down when set
  // open-drain line with a pull-up, either party may pull it low
  assign pinIn = !(pinOe || pinLow);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
    pinLow = 1'b0;
  end
  // one-cycle write, held through the taking edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // one-cycle read; data is checked by the bench a cycle later
  task automatic rd(input logic [6:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd
endmodule : gmc_host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the mode and command register bank
// assumes short offset and heat waits set at the instance
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import gmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pack_config_byte = 8'h80; // pin starts as input
  logic [15:0] heatSample = 16'h0000;
  logic [15:0] offsetSample = 16'h0000;
  logic [15:0] rate_capacity = 16'h0000;
  logic regWrite, regRead, pinIn, pinOut, pinOe;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic [15:0] nominal_capacity, ldc, rateIn, e, v;
  logic [15:0] ofs[2]; // external then internal offset samples
  logic fullCharge = 1'b0; // full charge event toward the bank
  logic exitProgram = 1'b0; // programming exit event toward the bank
  logic lif, prp, frp, shipMode, calibrating, internalShort, rdDly;
  logic [7:0] expQ[$]; // expected read bytes, oldest first
  logic [7:0] cmds[5] = '{8'h3f, 8'h1b, 8'h0b, 8'h03, 8'h01};
  integer seed = 16;
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  gmc_host_model u_host (.clk(clk), .pinOe(pinOe), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .pinIn(pinIn));
  gmc_mode_regs #(.OFFSET_WAIT(50), .HEAT_WAIT(20),
    .LAST_DISCHARGE_INIT(16'h1234)) u_gmc_mode_regs (.clk(clk),
    .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .pack_config_byte(pack_config_byte), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .heatSample(heatSample), .offsetSample(offsetSample),
    .rate_capacity(rate_capacity), .fullCharge(fullCharge),
    .exitProgram(exitProgram),
    .nominal_capacity(nominal_capacity), .last_discharge_capacity(ldc),
    .learning_invalid_flag(lif), .partialResetPulse(prp),
    .fullResetPulse(frp), .shipMode(shipMode), .calibrating(calibrating),
    .internalShort(internalShort));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    expQ.push_back(x);
    u_host.rd(a);
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // read data arrives the cycle after the read is taken
  always @(posedge clk)
  begin
    rdDly <= regRead;
    if (rdDly)
    begin
      if (expQ.size() == 0)
        chk(16'hdead, 16'h0000);
      else
        chk({8'h00, regRdata}, {8'h00, expQ.pop_front()});
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_MODE, 8'hc4);
    rd(7'h30, 8'h00);
    $display("test reset done");
    u_host.wr(ADDR_MODE, 8'h04);
    // driver enable is registered from the stored byte, one edge later
    repeat (2) @(posedge clk);
    chk({15'h0000, pinOe}, 16'h0001);
    rd(ADDR_MODE, 8'h04);
    u_host.pinLow <= 1'b1;
    u_host.wr(ADDR_MODE, 8'hc4);
    rd(ADDR_MODE, 8'h84);
    u_host.pinLow <= 1'b0;
    $display("test gpio done");
    rateIn = 16'($random(seed));
    v = 16'($random(seed));
    rate_capacity <= v;
    heatSample <= 16'($random(seed));
    u_host.wr(ADDR_RATE_LO, rateIn[7:0]);
    u_host.wr(ADDR_RATE_HI, rateIn[15:8]);
    u_host.wr(ADDR_RUN_LO, 8'hff);
    rd(ADDR_RATE_LO, rateIn[7:0]);
    rd(ADDR_RATE_HI, rateIn[15:8]);
    repeat (80) @(posedge clk);
    // zero rate or a quotient beyond sixteen bits reads as all ones
    e = 16'hffff;
    if (rateIn != 0 && 60 * v / rateIn <= 32'hffff)
      e = 16'(60 * v / rateIn);
    rd(ADDR_RUN_LO, e[7:0]);
    rd(ADDR_RUN_HI, e[15:8]);
    rd(ADDR_HEAT_LO, heatSample[7:0]);
    rd(ADDR_HEAT_HI, heatSample[15:8]);
    $display("test rate done");
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr(ADDR_MODE, cmds[i] | 8'h44);
      u_host.wr(ADDR_CONTROL, KEY_GAUGE);
      @(posedge clk);
      e = i == 0 ? rateIn : 16'h1234;
      if (i == 3)
        e = 16'h0000;
      if (i < 4)
        chk(nominal_capacity, e);
    end
    chk({15'h0000, shipMode}, 16'h0001);
    chk(ldc, 16'h1234);
    chk({15'h0000, lif}, 16'h0001);
    rd(ADDR_MODE, 8'h44);
    rd(ADDR_CONTROL, 8'h00);
    u_host.wr(ADDR_RATE_LO, rateIn[7:0]);
    rd(ADDR_MODE, 8'h40);
    chk({15'h0000, shipMode}, 16'h0000);
    u_host.wr(ADDR_MODE, 8'h5c);
    u_host.wr(ADDR_CONTROL, 8'h5a);
    rd(ADDR_MODE, 8'h5c);
    rd(ADDR_CONTROL, 8'h5a);
    // power-on flag cleared by full charge, then by programming exit
    for (int i = 0; i < 2; i++)
    begin
      u_host.wr(ADDR_MODE, 8'h44);
      {exitProgram, fullCharge} <= 2'(i + 1);
      @(posedge clk);
      {exitProgram, fullCharge} <= 2'b00;
      rd(ADDR_MODE, 8'h40);
    end
    $display("test commands done");
    // no current input exists at this block, so the bench keeps it idle
    for (int i = 0; i < 2; i++)
    begin
      ofs[i] = 16'($random(seed));
      offsetSample <= ofs[i];
      u_host.wr(ADDR_MODE, i == 0 ? 8'h64 : 8'h54);
      u_host.wr(ADDR_CONTROL, KEY_OFFSET);
      @(posedge clk);
      chk({14'h0000, calibrating, internalShort}, 16'(i + 2));
      for (int n = 0; n < 200 && calibrating === 1'b1; n++)
        @(posedge clk);
      if (calibrating !== 1'b0)
      begin
        mismatches++;
        $display("[ERR] %0t offset measurement never ended", $time);
        break;
      end
      rd(ADDR_OFS_LO, ofs[i][7:0]);
      rd(ADDR_OFS_HI, ofs[i][15:8]);
    end
    // board offset written to configuration bits 4:2, which the bank never reads
    pack_config_byte[4:2] <= 3'(ofs[0] - ofs[1]);
    rd(ADDR_MODE, 8'h44);
    $display("test offset done");
    repeat (3) @(posedge clk);
    results();
  end
endmodule : tb_top
`default_nettype wire
